// File: hdl/cpvdm_responder.sv
// Cable plug responder: answers discovery and mode requests from the
// downstream port, handles soft reset and escalates to hard reset.
// Assumes the protocol layer and policy manager share clk_sys and drive
// one-cycle pulses; hardResetPin is an asynchronous pin-level indication.
`timescale 1ns/100ps

// Overview of operation
// - Idle is home; reset lands in idle
// - Identity request fetches identity from manager
// - Identity delivered: send ACK, back to idle
// - SVIDs request fetches SVIDs from manager
// - SVIDs delivered: send ACK, back to idle
// - Modes request fetches modes from manager
// - Modes delivered: send ACK, back to idle
// - Enter request asks manager to judge entry
// - Mode entered: send Enter ACK, idle
// - Refused: send manager-directed NAK, idle
// - Exit request asks manager to leave mode
// - Mode left: send Exit ACK, idle
// - Soft reset message forces soft-reset state
// - Reset protocol layer, then request Accept
// - Accept sent returns to idle
// - Transmit error during soft reset: hard reset
// - Hard/cable reset: self reset, then idle
module cpvdm_responder (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // Protocol layer: received requests
  input  wire logic                  reqValid,
  input  wire logic [2:0]            reqCmd,
  input  wire logic                  softResetRx,
  input  wire logic                  hardResetPin,
  // Protocol layer: transmit path
  output logic                       txReq,
  output logic [2:0]                 txCmd,
  output logic [1:0]                 txKind,
  input  wire logic                  txDone,
  input  wire logic                  txError,
  output logic                       protoReset,
  // Policy manager exchange
  output logic                       dpmQuery,
  output logic [1:0]                 dpmQueryKind,
  output logic                       dpmEnterReq,
  output logic                       dpmExitReq,
  input  wire logic                  dpmInfoDone,
  input  wire logic                  dpmEnterOk,
  input  wire logic                  dpmEnterNak,
  input  wire logic                  dpmExitDone,
  // Status
  output cpvdm_pkg::cpvdm_state_t    stateOut
);
  import cpvdm_pkg::*;

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    cpvdm_state_t st;
    logic [2:0]   hrSync;      // Pin synchroniser, bit 0 is first stage
    logic         hrLevel;     // Agreed level of the hard reset pin
    logic         acceptPend;  // Accept request follows protocol reset
    logic         txReq;
    logic [2:0]   txCmd;
    logic [1:0]   txKind;
    logic         protoReset;
    logic         dpmQuery;
    logic [1:0]   dpmQueryKind;
    logic         dpmEnterReq;
    logic         dpmExitReq;
    logic         timerStart;
  } cpvdm_core_t;

  cpvdm_core_t cur;
  cpvdm_core_t next_cur;
  logic        timerDone;
  logic        hrRise;

  // ----------------------------------------------------------------------
  // Self reset timer
  // ----------------------------------------------------------------------
  cpvdm_reset_timer #(
    .CYCLES (SELF_RESET_CYC)
  ) u_timer (
    .clk_sys (clk_sys),
    .srst    (srst),
    .start   (cur.timerStart),
    .done    (timerDone)
  );

  // Edge once second and third stages agree high, prior level low
  assign hrRise = cur.hrSync[1] & cur.hrSync[2] & ~cur.hrLevel;

  // Start a reply transfer toward the protocol layer
  function automatic cpvdm_core_t sendRsp(input cpvdm_core_t c,
                                          input logic [2:0] cmd,
                                          input logic [1:0] kind);
    cpvdm_core_t r;
    r        = c;
    r.txReq  = 1'b1;
    r.txCmd  = cmd;
    r.txKind = kind;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur              = cur;
    next_cur.txReq        = 1'b0;
    next_cur.protoReset   = 1'b0;
    next_cur.dpmQuery     = 1'b0;
    next_cur.dpmEnterReq  = 1'b0;
    next_cur.dpmExitReq   = 1'b0;
    next_cur.timerStart   = 1'b0;
    next_cur.acceptPend   = 1'b0;
    next_cur.hrSync       = {cur.hrSync[1:0], hardResetPin};
    if (cur.hrSync[1] == cur.hrSync[2]) begin
      next_cur.hrLevel = cur.hrSync[2];
    end

    if (hrRise) begin
      // Hard reset outranks everything, including soft reset
      next_cur.st         = cable_hard_reset_state;
      next_cur.timerStart = 1'b1;
    end else if (softResetRx && cur.st != cable_hard_reset_state) begin
      // Protocol layer is reset first; Accept goes out next cycle
      next_cur.st         = cable_soft_reset_state;
      next_cur.protoReset = 1'b1;
      next_cur.acceptPend = 1'b1;
    end else begin
      case (cur.st)
        cable_idle_state: begin
          // Requests are only accepted when idle
          if (reqValid) begin
            case (reqCmd)
              CMD_DISC_IDENT: begin
                next_cur.st           = cable_identity_fetch_state;
                next_cur.dpmQuery     = 1'b1;
                next_cur.dpmQueryKind = QRY_IDENT;
              end
              CMD_DISC_SVIDS: begin
                next_cur.st           = cable_svid_fetch_state;
                next_cur.dpmQuery     = 1'b1;
                next_cur.dpmQueryKind = QRY_SVIDS;
              end
              CMD_DISC_MODES: begin
                next_cur.st           = cable_modes_fetch_state;
                next_cur.dpmQuery     = 1'b1;
                next_cur.dpmQueryKind = QRY_MODES;
              end
              CMD_ENTER_MODE: begin
                next_cur.st          = cable_entry_evaluation_state;
                next_cur.dpmEnterReq = 1'b1;
              end
              CMD_EXIT_MODE: begin
                next_cur.st         = cable_mode_leave_state;
                next_cur.dpmExitReq = 1'b1;
              end
              default: begin
                next_cur.st = cable_idle_state;
              end
            endcase
          end
        end
        cable_identity_fetch_state: begin
          if (dpmInfoDone) begin
            next_cur    = sendRsp(next_cur, CMD_DISC_IDENT, RSP_ACK);
            next_cur.st = cable_identity_reply_state;
          end
        end
        cable_svid_fetch_state: begin
          if (dpmInfoDone) begin
            next_cur    = sendRsp(next_cur, CMD_DISC_SVIDS, RSP_ACK);
            next_cur.st = cable_svid_reply_state;
          end
        end
        cable_modes_fetch_state: begin
          if (dpmInfoDone) begin
            next_cur    = sendRsp(next_cur, CMD_DISC_MODES, RSP_ACK);
            next_cur.st = cable_modes_reply_state;
          end
        end
        cable_entry_evaluation_state: begin
          // Accept wins if the manager ever pulses both
          if (dpmEnterOk) begin
            next_cur    = sendRsp(next_cur, CMD_ENTER_MODE, RSP_ACK);
            next_cur.st = cable_entry_accept_state;
          end else if (dpmEnterNak) begin
            next_cur    = sendRsp(next_cur, CMD_ENTER_MODE, RSP_NAK);
            next_cur.st = cable_entry_reject_state;
          end
        end
        cable_mode_leave_state: begin
          if (dpmExitDone) begin
            next_cur    = sendRsp(next_cur, CMD_EXIT_MODE, RSP_ACK);
            next_cur.st = cable_leave_accept_state;
          end
        end
        cable_identity_reply_state,
        cable_svid_reply_state,
        cable_modes_reply_state,
        cable_entry_accept_state,
        cable_entry_reject_state,
        cable_leave_accept_state: begin
          // Back to idle once the response has gone out
          if (txDone) begin
            next_cur.st = cable_idle_state;
          end
        end
        cable_soft_reset_state: begin
          if (cur.acceptPend) begin
            next_cur = sendRsp(next_cur, 3'h0, RSP_ACCEPT);
          end else if (txError) begin
            next_cur.st         = cable_hard_reset_state;
            next_cur.timerStart = 1'b1;
          end else if (txDone) begin
            next_cur.st = cable_idle_state;
          end
        end
        cable_hard_reset_state: begin
          // Outputs stay quiet until the self reset finishes
          if (timerDone) begin
            next_cur.st = cable_idle_state;
          end
        end
        default: begin
          next_cur.st = cable_idle_state;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur    <= '0;
      cur.st <= cable_idle_state;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  assign txReq        = cur.txReq;
  assign txCmd        = cur.txCmd;
  assign txKind       = cur.txKind;
  assign protoReset   = cur.protoReset;
  assign dpmQuery     = cur.dpmQuery;
  assign dpmQueryKind = cur.dpmQueryKind;
  assign dpmEnterReq  = cur.dpmEnterReq;
  assign dpmExitReq   = cur.dpmExitReq;
  assign stateOut     = cur.st;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_RESET_IDLE: assert property (@(posedge clk_sys)
    srst |=> stateOut == cable_idle_state)
    else $error("not idle after reset");

  AST_IDENT_FETCH: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_idle_state && reqValid && reqCmd == CMD_DISC_IDENT
     && !softResetRx && !hrRise)
    |=> stateOut == cable_identity_fetch_state && dpmQuery
        && dpmQueryKind == QRY_IDENT)
    else $error("identity fetch not started");

  AST_IDENT_ACK: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_identity_fetch_state && dpmInfoDone
     && !softResetRx && !hrRise)
    |=> txReq && txKind == RSP_ACK && txCmd == CMD_DISC_IDENT)
    else $error("identity ack not sent");

  AST_SVID_FETCH: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_idle_state && reqValid && reqCmd == CMD_DISC_SVIDS
     && !softResetRx && !hrRise) |=> dpmQuery && dpmQueryKind == QRY_SVIDS)
    else $error("svid fetch not started");

  AST_MODES_FETCH: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_idle_state && reqValid && reqCmd == CMD_DISC_MODES
     && !softResetRx && !hrRise) |=> dpmQuery && dpmQueryKind == QRY_MODES)
    else $error("modes fetch not started");

  AST_ENTER_NAK: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_entry_evaluation_state && dpmEnterNak && !dpmEnterOk
     && !softResetRx && !hrRise)
    |=> stateOut == cable_entry_reject_state && txKind == RSP_NAK)
    else $error("enter nak not sent");

  AST_SOFT_ORDER: assert property (@(posedge clk_sys) disable iff (srst)
    (softResetRx && !hrRise && stateOut != cable_hard_reset_state)
    |=> protoReset && !txReq ##1 txReq && txKind == RSP_ACCEPT)
    else $error("accept before protocol reset");

  AST_SOFT_ERR: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_soft_reset_state && !protoReset && txError
     && !softResetRx && !hrRise) |=> stateOut == cable_hard_reset_state)
    else $error("tx error did not escalate");

  AST_HARD_ENTRY: assert property (@(posedge clk_sys) disable iff (srst)
    hrRise |=> stateOut == cable_hard_reset_state
               ##[1:20] stateOut == cable_idle_state)
    else $error("hard reset not entered or not left");

  AST_PULSE: assert property (@(posedge clk_sys) disable iff (srst)
    dpmQuery |=> !dpmQuery)
    else $error("query longer than one cycle");

  AST_SVID_ACK: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_svid_fetch_state && dpmInfoDone
     && !softResetRx && !hrRise)
    |=> stateOut == cable_svid_reply_state && txReq && txKind == RSP_ACK
        && txCmd == CMD_DISC_SVIDS)
    else $error("svid ack not sent");

  AST_MODES_ACK: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_modes_fetch_state && dpmInfoDone
     && !softResetRx && !hrRise)
    |=> stateOut == cable_modes_reply_state && txReq && txKind == RSP_ACK
        && txCmd == CMD_DISC_MODES)
    else $error("modes ack not sent");

  AST_ENTER_ACK: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_entry_evaluation_state && dpmEnterOk
     && !softResetRx && !hrRise)
    |=> stateOut == cable_entry_accept_state && txReq && txKind == RSP_ACK
        && txCmd == CMD_ENTER_MODE)
    else $error("enter ack not sent");

  AST_EXIT_REQ: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_idle_state && reqValid && reqCmd == CMD_EXIT_MODE
     && !softResetRx && !hrRise)
    |=> stateOut == cable_mode_leave_state && dpmExitReq)
    else $error("exit request not passed on");

  AST_EXIT_ACK: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_mode_leave_state && dpmExitDone
     && !softResetRx && !hrRise)
    |=> stateOut == cable_leave_accept_state && txReq && txKind == RSP_ACK
        && txCmd == CMD_EXIT_MODE)
    else $error("exit ack not sent");

  AST_SOFT_ENTRY: assert property (@(posedge clk_sys) disable iff (srst)
    (softResetRx && !hrRise && stateOut != cable_hard_reset_state)
    |=> stateOut == cable_soft_reset_state)
    else $error("soft reset state not entered");

  AST_SOFT_DONE: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut == cable_soft_reset_state && !protoReset && txDone
     && !txError && !softResetRx && !hrRise)
    |=> stateOut == cable_idle_state)
    else $error("accept sent but not idle");

  AST_REPLY_IDLE: assert property (@(posedge clk_sys) disable iff (srst)
    (stateOut inside {cable_identity_reply_state, cable_svid_reply_state,
                      cable_modes_reply_state, cable_entry_accept_state,
                      cable_entry_reject_state, cable_leave_accept_state}
     && txDone && !softResetRx && !hrRise) |=> stateOut == cable_idle_state)
    else $error("reply state did not return to idle");

endmodule // cpvdm_responder

// File: shared/cpvdm_pkg.sv
// Shared constants and types for the cable plug structured message responder.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package cpvdm_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  // Cycles the plug holds its self reset after hard or cable reset
  localparam int unsigned SELF_RESET_NS  = 200;
  localparam int unsigned SELF_RESET_CYC =
    (SELF_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 8;

  // ----------------------------------------------------------------------
  // Request command codes from the protocol layer
  // ----------------------------------------------------------------------
  localparam logic [2:0] CMD_DISC_IDENT = 3'h1;
  localparam logic [2:0] CMD_DISC_SVIDS = 3'h2;
  localparam logic [2:0] CMD_DISC_MODES = 3'h3;
  localparam logic [2:0] CMD_ENTER_MODE = 3'h4;
  localparam logic [2:0] CMD_EXIT_MODE  = 3'h5;

  // ----------------------------------------------------------------------
  // Response kinds handed to the protocol layer
  // ----------------------------------------------------------------------
  localparam logic [1:0] RSP_ACK    = 2'h0;
  localparam logic [1:0] RSP_NAK    = 2'h1;
  localparam logic [1:0] RSP_ACCEPT = 2'h2;

  // Policy manager query kinds
  localparam logic [1:0] QRY_IDENT = 2'h0;
  localparam logic [1:0] QRY_SVIDS = 2'h1;
  localparam logic [1:0] QRY_MODES = 2'h2;

  // ----------------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    cable_idle_state,
    cable_identity_fetch_state,
    cable_identity_reply_state,
    cable_svid_fetch_state,
    cable_svid_reply_state,
    cable_modes_fetch_state,
    cable_modes_reply_state,
    cable_entry_evaluation_state,
    cable_entry_accept_state,
    cable_entry_reject_state,
    cable_mode_leave_state,
    cable_leave_accept_state,
    cable_soft_reset_state,
    cable_hard_reset_state
  } cpvdm_state_t;

endpackage

// File: hdl/cpvdm_reset_timer.sv
// Self-reset timer for the cable plug responder.
// Assumes start is a one-cycle pulse on the same clock as the caller.
`timescale 1ns/100ps
module cpvdm_reset_timer #(
  parameter int unsigned CYCLES = cpvdm_pkg::SELF_RESET_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Control
  input  wire logic start,
  output logic      done
);
  import cpvdm_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             busy;
    logic             done;
  } cpvdm_tmr_t;

  cpvdm_tmr_t cur;
  cpvdm_tmr_t next_cur;

  // ----------------------------------------------------------------------
  // Countdown; done pulses once when the count runs out
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    if (start) begin
      // Restart wins so a second reset stretches the window
      next_cur.count = CNT_W'(CYCLES);
      next_cur.busy  = 1'b1;
    end else if (cur.busy) begin
      if (cur.count <= CNT_W'(1)) begin
        next_cur.busy = 1'b0;
        next_cur.done = 1'b1;
      end else begin
        next_cur.count = cur.count - CNT_W'(1);
      end
    end
  end

  // Register state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done = cur.done;

endmodule // cpvdm_reset_timer

// File: verif/cpvdm_partner.sv
// Model of the policy manager and protocol layer facing the responder.
// Assumes one clock with the responder; answers are one-cycle pulses.
`timescale 1ns/100ps
module cpvdm_partner (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Scenario controls
  input  wire logic slow,
  input  wire logic refuse,
  input  wire logic txFail,
  // Requests from the responder
  input  wire logic dpmQuery,
  input  wire logic dpmEnterReq,
  input  wire logic dpmExitReq,
  input  wire logic txReq,
  input  wire logic protoReset,
  // Answers to the responder
  output logic      dpmInfoDone,
  output logic      dpmEnterOk,
  output logic      dpmEnterNak,
  output logic      dpmExitDone,
  output logic      txDone,
  output logic      txError
);
  // ----------------------------------------------------------------------
  // Answer engines
  // ----------------------------------------------------------------------
  logic [1:0] pend;
  logic [1:0] cnt;
  logic       txPend;
  logic [1:0] txCnt;

  // Manager and transmitter run apart so Accept is never lost
  always @(posedge clk_sys) begin
    {dpmInfoDone, dpmEnterOk, dpmEnterNak, dpmExitDone} <= '0;
    {txDone, txError} <= '0;
    if (srst) begin
      pend   <= '0;
      txPend <= 1'b0;
    end else begin
      if (pend == 2'd0) begin
        cnt <= slow ? 2'd3 : 2'd0;
        if (dpmQuery) pend <= 2'd1;
        if (dpmEnterReq) pend <= 2'd2;
        if (dpmExitReq) pend <= 2'd3;
      end else if (cnt != 2'd0) begin
        cnt <= cnt - 2'd1;
      end else begin
        pend <= 2'd0;
        dpmInfoDone <= (pend == 2'd1);
        dpmEnterOk  <= (pend == 2'd2) && !refuse;
        dpmEnterNak <= (pend == 2'd2) && refuse;
        dpmExitDone <= (pend == 2'd3);
      end
      // Protocol reset drops a half-sent response
      if (protoReset) begin
        txPend <= 1'b0;
      end else if (!txPend) begin
        txCnt  <= slow ? 2'd3 : 2'd0;
        txPend <= txReq;
      end else if (txCnt != 2'd0) begin
        txCnt <= txCnt - 2'd1;
      end else begin
        txPend  <= 1'b0;
        txDone  <= !txFail;
        txError <= txFail;
      end
    end
  end
endmodule // cpvdm_partner

// File: verif/tb_cable_plug_vdm_responder.sv
// Self-checking bench for the cable plug responder.
// Assumes the partner model answers requests; bench drives the DFP side.
`timescale 1ns/100ps
module tb_cable_plug_vdm_responder;
  import cpvdm_pkg::*;
  logic clk_sys = 1'b0;
  logic srst, reqValid, softResetRx, hardResetPin, slow, refuse, txFail;
  logic [2:0] reqCmd, txCmd;
  logic [1:0] txKind, dpmQueryKind;
  logic txReq, txDone, txError, protoReset, dpmQuery, dpmEnterReq;
  logic dpmExitReq, dpmInfoDone, dpmEnterOk, dpmEnterNak, dpmExitDone;
  cpvdm_state_t stateOut;
  int n_errors = 0;
  int compares = 0;

  always #10 clk_sys = ~clk_sys;

  cpvdm_responder cpvdm_responder_i (.clk_sys(clk_sys), .srst(srst),
    .reqValid(reqValid), .reqCmd(reqCmd), .softResetRx(softResetRx),
    .hardResetPin(hardResetPin), .txReq(txReq), .txCmd(txCmd),
    .txKind(txKind), .txDone(txDone), .txError(txError),
    .protoReset(protoReset), .dpmQuery(dpmQuery),
    .dpmQueryKind(dpmQueryKind), .dpmEnterReq(dpmEnterReq),
    .dpmExitReq(dpmExitReq), .dpmInfoDone(dpmInfoDone),
    .dpmEnterOk(dpmEnterOk), .dpmEnterNak(dpmEnterNak),
    .dpmExitDone(dpmExitDone), .stateOut(stateOut));

  cpvdm_partner cpvdm_partner_i (.clk_sys(clk_sys), .srst(srst),
    .slow(slow), .refuse(refuse), .txFail(txFail), .dpmQuery(dpmQuery),
    .dpmEnterReq(dpmEnterReq), .dpmExitReq(dpmExitReq), .txReq(txReq),
    .protoReset(protoReset), .dpmInfoDone(dpmInfoDone),
    .dpmEnterOk(dpmEnterOk), .dpmEnterNak(dpmEnterNak),
    .dpmExitDone(dpmExitDone), .txDone(txDone), .txError(txError));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task end_sim;
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk_v(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_st(input cpvdm_state_t got, input cpvdm_state_t exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sample 1 ns after the edge, once values have settled
  task tick;
    @(posedge clk_sys);
    #1;
  endtask

  task send(input logic [2:0] cmd);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqCmd   <= cmd;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    #1;
  endtask

  task soft_pulse;
    @(posedge clk_sys);
    softResetRx <= 1'b1;
    @(posedge clk_sys);
    softResetRx <= 1'b0;
    #1;
  endtask

  // Bounded waits, so a stuck machine shows up as a mismatch
  task wait_st(input cpvdm_state_t s, input int lim);
    for (int i = 0; i < lim && stateOut !== s; i++) tick;
    chk_st(stateOut, s);
  endtask

  task wait_tx;
    for (int i = 0; i < 20 && txReq !== 1'b1; i++) tick;
    chk_v(4'(txReq), 4'h1);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    tick;
    chk_st(stateOut, cable_idle_state);
    chk_v({txReq, protoReset, dpmQuery, dpmEnterReq}, 4'h0);
    // Unknown request code is dropped silently
    send(3'h6);
    chk_st(stateOut, cable_idle_state);
    chk_v({dpmQuery, dpmEnterReq, dpmExitReq, txReq}, 4'h0);
  endtask

  task automatic t_disc;
    logic [2:0] c[3] = '{CMD_DISC_IDENT, CMD_DISC_SVIDS, CMD_DISC_MODES};
    logic [1:0] q[3] = '{QRY_IDENT, QRY_SVIDS, QRY_MODES};
    cpvdm_state_t f[3] = '{cable_identity_fetch_state,
      cable_svid_fetch_state, cable_modes_fetch_state};
    cpvdm_state_t r[3] = '{cable_identity_reply_state,
      cable_svid_reply_state, cable_modes_reply_state};
    for (int k = 0; k < 3; k++) begin
      slow <= (k == 1);
      send(c[k]);
      chk_st(stateOut, f[k]);
      chk_v(4'(dpmQuery), 4'h1);
      chk_v(4'(dpmQueryKind), 4'(q[k]));
      tick;
      chk_v(4'(dpmQuery), 4'h0);
      wait_tx;
      chk_st(stateOut, r[k]);
      chk_v({txKind, 2'b00}, {RSP_ACK, 2'b00});
      chk_v(4'(txCmd), 4'(c[k]));
      wait_st(cable_idle_state, 10);
    end
  endtask

  task t_mode;
    for (int k = 0; k < 2; k++) begin
      refuse <= k[0];
      send(CMD_ENTER_MODE);
      chk_st(stateOut, cable_entry_evaluation_state);
      chk_v(4'(dpmEnterReq), 4'h1);
      wait_tx;
      chk_st(stateOut, k ? cable_entry_reject_state
                         : cable_entry_accept_state);
      chk_v(4'(txKind), k ? 4'(RSP_NAK) : 4'(RSP_ACK));
      chk_v(4'(txCmd), 4'(CMD_ENTER_MODE));
      wait_st(cable_idle_state, 10);
    end
    send(CMD_EXIT_MODE);
    chk_st(stateOut, cable_mode_leave_state);
    chk_v(4'(dpmExitReq), 4'h1);
    wait_tx;
    chk_st(stateOut, cable_leave_accept_state);
    chk_v({txKind, 2'b00}, {RSP_ACK, 2'b00});
    chk_v(4'(txCmd), 4'(CMD_EXIT_MODE));
    wait_st(cable_idle_state, 10);
  endtask

  // Request while busy is ignored, then soft reset cuts the fetch short
  task t_soft;
    slow <= 1'b1;
    send(CMD_DISC_MODES);
    send(CMD_DISC_IDENT);
    chk_st(stateOut, cable_modes_fetch_state);
    chk_v(4'(dpmQuery), 4'h0);
    soft_pulse;
    chk_st(stateOut, cable_soft_reset_state);
    chk_v({protoReset, txReq}, 4'h2);
    tick;
    chk_v({protoReset, txReq}, 4'h1);
    chk_v(4'(txKind), 4'(RSP_ACCEPT));
    wait_st(cable_idle_state, 10);
    txFail <= 1'b1;
    soft_pulse;
    wait_st(cable_hard_reset_state, 10);
    txFail <= 1'b0;
    wait_st(cable_idle_state, 30);
  endtask

  task t_hard;
    slow <= 1'b1;
    send(CMD_ENTER_MODE);
    hardResetPin <= 1'b1;
    wait_st(cable_hard_reset_state, 8);
    send(CMD_DISC_IDENT);
    chk_st(stateOut, cable_hard_reset_state);
    chk_v({txReq, dpmQuery, dpmEnterReq, protoReset}, 4'h0);
    wait_st(cable_idle_state, 20);
    slow <= 1'b0;
    send(CMD_DISC_SVIDS);
    chk_st(stateOut, cable_svid_fetch_state);
    wait_st(cable_idle_state, 10);
    hardResetPin <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    reqValid = 1'b0;
    reqCmd = 3'h0;
    softResetRx = 1'b0;
    hardResetPin = 1'b0;
    slow = 1'b0;
    refuse = 1'b0;
    txFail = 1'b0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_disc;
    t_mode;
    t_soft;
    t_hard;
    end_sim;
  end

  // Whole run is about 125 cycles; this is far past it
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    end_sim;
  end
endmodule // tb_cable_plug_vdm_responder
